// ### core/gpc_cfg.svh
`ifndef GPC_CFG_SVH
`define GPC_CFG_SVH
// register byte addresses on the avalon slave
`define GPC_OFF_LATCH0  6'h00
`define GPC_OFF_LATCH1  6'h04
`define GPC_OFF_LATCH2  6'h08
`define GPC_OFF_LATCH3  6'h0c
`define GPC_OFF_MLO0    6'h10
`define GPC_OFF_MLO1    6'h14
`define GPC_OFF_MLO2    6'h18
`define GPC_OFF_MHI0    6'h1c
`define GPC_OFF_MHI1    6'h20
`define GPC_OFF_MHI2    6'h24
`define GPC_OFF_P3CFGA  6'h28
`define GPC_OFF_P3CFGB  6'h2c
`define GPC_OFF_PIN0    6'h30
`define GPC_OFF_PIN1    6'h34
`define GPC_OFF_PIN2    6'h38
`define GPC_OFF_PIN3    6'h3c
// reset values
`define GPC_RST_LATCH   8'hff
`define GPC_RST_LATCH3  8'h03
`define GPC_RST_MODE    8'h00
`define GPC_RST_CFG     8'h00
// port 3 config a field positions
`define GPC_A_SCHMITT_LSB 4
`define GPC_A_T0OE        2
`define GPC_A_T1OE        3
// port 3 config b field positions
`define GPC_B_CLKOUT_EN   2
// bus pins on port 1
`define GPC_BUS_CLK_BIT   2
`define GPC_BUS_DAT_BIT   3
// strong pull-up pulse: two peripheral clocks
`define GPC_STRONG_CYC    2'd2
// clock output divider: divide by 4
`define GPC_CLKDIV_HALF   1'b1
// avalon read answer: one wait state
`define GPC_AV_WAIT       1'b1
`endif

// ### core/gpc_pkg.sv
package gpc_pkg;
  typedef enum logic [1:0] {
    GPC_QUASI,
    GPC_PUSHPULL,
    GPC_INPUT,
    GPC_OPENDRAIN
  } gpc_mode_e;

  // per-pin driver controls toward the pad
  typedef struct packed {
    logic very_weak_pu;
    logic weak_pu;
    logic strong_pu;
    logic pull_down;
  } gpc_drv_s;

  // port-level rmw write command
  typedef struct packed {
    logic       valid;
    logic [1:0] port;
    logic [1:0] op;
    logic [2:0] bit_idx;
    logic [7:0] operand;
  } gpc_rmw_s;

  typedef enum logic [1:0] {
    GPC_OP_WRITE,
    GPC_OP_AND,
    GPC_OP_OR,
    GPC_OP_XOR
  } gpc_op_e;
endpackage

// ### core/gpc_pin_cell.sv
`timescale 1ns/1ps
`include "gpc_cfg.svh"
// one pad's driver controls
module gpc_pin_cell (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              latch,
  input  wire logic [1:0]        mode,
  input  wire logic              force_od,
  input  wire logic              disable_io,
  input  wire logic              pin_level,
  output gpc_pkg::gpc_drv_s      drv
);
  gpc_pkg::gpc_mode_e eff_mode;
  logic       latch_q;
  logic [1:0] strong_cnt_q;

  // ==========================================
  // mode decode
  always_comb begin
    if (force_od) begin
      eff_mode = gpc_pkg::GPC_OPENDRAIN;
    end else begin
      case (mode)
        2'b00:   eff_mode = gpc_pkg::GPC_QUASI;
        2'b10:   eff_mode = gpc_pkg::GPC_PUSHPULL;
        2'b01:   eff_mode = gpc_pkg::GPC_INPUT;
        default: eff_mode = gpc_pkg::GPC_OPENDRAIN;
      endcase
    end
  end

  // ==========================================
  // strong pull-up pulse on a latch rise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      latch_q <= 1'b1;
    end else begin
      latch_q <= latch;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strong_cnt_q <= 2'd0;
    end else if (latch && !latch_q) begin
      strong_cnt_q <= `GPC_STRONG_CYC;
    end else if (!latch) begin
      strong_cnt_q <= 2'd0;
    end else if (strong_cnt_q != 2'd0) begin
      strong_cnt_q <= strong_cnt_q - 2'd1;
    end
  end

  // ==========================================
  // driver outputs
  always_comb begin
    drv = '0;
    if (!disable_io) begin
      case (eff_mode)
        gpc_pkg::GPC_QUASI: begin
          drv.very_weak_pu = latch;
          drv.weak_pu      = latch && pin_level;
          // latch-gated so a mid-pulse fall never fights the pull-down
          drv.strong_pu    = latch && (strong_cnt_q != 2'd0);
          drv.pull_down    = !latch;
        end
        gpc_pkg::GPC_PUSHPULL: begin
          drv.strong_pu = latch;
          drv.pull_down = !latch;
        end
        gpc_pkg::GPC_OPENDRAIN: begin
          drv.pull_down = !latch;
        end
        gpc_pkg::GPC_INPUT: begin
          drv = '0;
        end
        default: begin
          drv = '0;
        end
      endcase
    end
  end
endmodule

// ### core/gpc_top.sv
`timescale 1ns/1ps
`include "gpc_cfg.svh"
module gpc_top (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic [5:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic [31:0]              avs_readdata,
  output logic                     avs_waitrequest,
  input  wire gpc_pkg::gpc_rmw_s   rmw_cmd,
  input  wire logic                xtal_sel,
  input  wire logic                osc_clk_sel,
  input  wire logic [31:0]         pin_in,
  output gpc_pkg::gpc_drv_s [31:0] pin_drv,
  output logic [31:0]              pin_oe,
  output logic [31:0]              pin_out,
  output logic [3:0]               schmitt_sel,
  output logic                     t0_toggle_en,
  output logic                     t1_toggle_en,
  output logic                     clkout_active
);
  logic [7:0]  latch_q [4];
  logic [7:0]  mlo_q   [3];
  logic [7:0]  mhi_q   [3];
  logic [7:0]  port3_config_a_q;
  logic [7:0]  port3_config_b_q;
  logic [31:0] pin_sync_q;
  logic [31:0] readdata_q;
  logic        rd_pend_q;
  logic [1:0]  div_q;
  logic        clk_out_q;
  logic [31:0] latch_flat;
  logic [31:0] mlo_flat;
  logic [31:0] mhi_flat;
  logic        wr_go;
  logic [7:0]  rmw_new;
  logic [7:0]  wr_byte;
  logic        osc_clkout_on;
  logic [7:0]  pin3_view;

  // ==========================================
  // avalon slave: writes finish at once, reads take one wait
  assign wr_go   = avs_write;
  assign wr_byte = avs_byteenable[0] ? avs_writedata[7:0] : 8'h00;
  assign avs_waitrequest = avs_read && !rd_pend_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_pend_q <= 1'b0;
    end else begin
      rd_pend_q <= avs_read && !rd_pend_q;
    end
  end

  // ==========================================
  // rmw path: source is always the latch
  always_comb begin
    rmw_new = latch_q[rmw_cmd.port];
    case (rmw_cmd.op)
      gpc_pkg::GPC_OP_AND: rmw_new = latch_q[rmw_cmd.port] & rmw_cmd.operand;
      gpc_pkg::GPC_OP_OR:  rmw_new = latch_q[rmw_cmd.port] | rmw_cmd.operand;
      gpc_pkg::GPC_OP_XOR: rmw_new = latch_q[rmw_cmd.port] ^ rmw_cmd.operand;
      gpc_pkg::GPC_OP_WRITE: begin
        // single-bit write of operand[0], others kept
        rmw_new[rmw_cmd.bit_idx] = rmw_cmd.operand[0];
      end
      default: rmw_new = latch_q[rmw_cmd.port];
    endcase
  end

  // ==========================================
  // output latches; bus write wins over a same-cycle rmw
  genvar p;
  generate
    for (p = 0; p < 4; p++) begin : g_latch
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          latch_q[p] <= (p == 3) ? `GPC_RST_LATCH3 : `GPC_RST_LATCH;
        end else if (wr_go && avs_address == 6'(p * 4)) begin
          latch_q[p] <= (p == 3) ? (wr_byte & 8'h03) : wr_byte;
        end else if (rmw_cmd.valid && rmw_cmd.port == 2'(p)) begin
          latch_q[p] <= (p == 3) ? (rmw_new & 8'h03) : rmw_new;
        end
      end
    end
    for (p = 0; p < 3; p++) begin : g_mode
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          mlo_q[p] <= `GPC_RST_MODE;
          mhi_q[p] <= `GPC_RST_MODE;
        end else if (wr_go) begin
          if (avs_address == 6'(`GPC_OFF_MLO0 + p * 4)) begin
            mlo_q[p] <= wr_byte;
          end
          if (avs_address == 6'(`GPC_OFF_MHI0 + p * 4)) begin
            mhi_q[p] <= wr_byte;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port3_config_a_q <= `GPC_RST_CFG;
      port3_config_b_q <= `GPC_RST_CFG;
    end else if (wr_go) begin
      if (avs_address == `GPC_OFF_P3CFGA) begin
        port3_config_a_q <= wr_byte;
      end
      if (avs_address == `GPC_OFF_P3CFGB) begin
        port3_config_b_q <= wr_byte & 8'h07;
      end
    end
  end

  // ==========================================
  // pin sampling: pins taken as synchronous, one register stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_sync_q <= 32'h0;
    end else begin
      pin_sync_q <= pin_in;
    end
  end

  // crystal pins read as zero: they are no longer port inputs
  assign pin3_view = {pin_sync_q[31:26],
                      pin_sync_q[25:24] & ~{2{xtal_sel}}};

  // ==========================================
  // read mux: latch offsets give latch, pin offsets give pins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      readdata_q <= 32'h0;
    end else if (avs_read && !rd_pend_q) begin
      case (avs_address)
        `GPC_OFF_LATCH0: readdata_q <= {24'h0, latch_q[0]};
        `GPC_OFF_LATCH1: readdata_q <= {24'h0, latch_q[1]};
        `GPC_OFF_LATCH2: readdata_q <= {24'h0, latch_q[2]};
        `GPC_OFF_LATCH3: readdata_q <= {24'h0, latch_q[3]};
        `GPC_OFF_MLO0:   readdata_q <= {24'h0, mlo_q[0]};
        `GPC_OFF_MLO1:   readdata_q <= {24'h0, mlo_q[1]};
        `GPC_OFF_MLO2:   readdata_q <= {24'h0, mlo_q[2]};
        `GPC_OFF_MHI0:   readdata_q <= {24'h0, mhi_q[0]};
        `GPC_OFF_MHI1:   readdata_q <= {24'h0, mhi_q[1]};
        `GPC_OFF_MHI2:   readdata_q <= {24'h0, mhi_q[2]};
        `GPC_OFF_P3CFGA: readdata_q <= {24'h0, port3_config_a_q};
        `GPC_OFF_P3CFGB: readdata_q <= {24'h0, port3_config_b_q};
        `GPC_OFF_PIN0:   readdata_q <= {24'h0, pin_sync_q[7:0]};
        `GPC_OFF_PIN1:   readdata_q <= {24'h0, pin_sync_q[15:8]};
        `GPC_OFF_PIN2:   readdata_q <= {24'h0, pin_sync_q[23:16]};
        `GPC_OFF_PIN3:   readdata_q <= {24'h0, pin3_view};
        default:         readdata_q <= 32'h0;
      endcase
    end
  end
  assign avs_readdata = readdata_q;

  // ==========================================
  // misc enables from port 3 config
  assign schmitt_sel  = port3_config_a_q[`GPC_A_SCHMITT_LSB +: 4];
  assign t0_toggle_en = port3_config_a_q[`GPC_A_T0OE];
  assign t1_toggle_en = port3_config_a_q[`GPC_A_T1OE];

  // ==========================================
  // clock output: clk stands for the oscillator source here
  assign osc_clkout_on = port3_config_b_q[`GPC_B_CLKOUT_EN] && osc_clk_sel;
  assign clkout_active = osc_clkout_on;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_q     <= 2'd0;
      clk_out_q <= 1'b0;
    end else if (osc_clkout_on) begin
      div_q <= div_q + 2'd1;
      if (div_q[0] == `GPC_CLKDIV_HALF) begin
        clk_out_q <= !clk_out_q;
      end
    end else begin
      div_q     <= 2'd0;
      clk_out_q <= 1'b0;
    end
  end

  // ==========================================
  // flatten per-pin configuration
  assign latch_flat = {latch_q[3], latch_q[2], latch_q[1], latch_q[0]};
  assign mlo_flat   = {6'h0, port3_config_a_q[1:0], mlo_q[2], mlo_q[1],
                       mlo_q[0]};
  assign mhi_flat   = {6'h0, port3_config_b_q[1:0], mhi_q[2], mhi_q[1],
                       mhi_q[0]};

  genvar i;
  generate
    for (i = 0; i < 32; i++) begin : g_pin
      logic force_od;
      logic dis_io;
      logic drive_latch;
      assign force_od = (i == 8 + `GPC_BUS_CLK_BIT) ||
                        (i == 8 + `GPC_BUS_DAT_BIT);
      // crystal mode takes both oscillator pins from the port
      assign dis_io = (i == 24 || i == 25) && xtal_sel;
      // pin 3.0 carries the divided clock when enabled
      assign drive_latch = (i == 24 && osc_clkout_on) ?
                           clk_out_q : latch_flat[i];
      gpc_pin_cell u_cell (
        .clk        (clk),
        .rst        (rst),
        .latch      (drive_latch),
        .mode       ({mhi_flat[i], mlo_flat[i]}),
        .force_od   (force_od),
        .disable_io (dis_io),
        .pin_level  (pin_sync_q[i]),
        .drv        (pin_drv[i])
      );
      assign pin_oe[i]  = pin_drv[i].strong_pu || pin_drv[i].pull_down ||
                          pin_drv[i].weak_pu || pin_drv[i].very_weak_pu;
      assign pin_out[i] = !pin_drv[i].pull_down;
    end
  endgenerate
endmodule

// ### verification/gpc_top_properties.sv
`timescale 1ns/1ps
// ====
// port checker
module gpc_top_properties (
  input wire logic                     clk,
  input wire logic                     rst,
  input wire logic                     avs_read,
  input wire logic                     avs_write,
  input wire logic [31:0]              avs_readdata,
  input wire logic                     avs_waitrequest,
  input wire logic [31:0]              pin_in,
  input wire gpc_pkg::gpc_drv_s [31:0] pin_drv,
  input wire logic [31:0]              pin_oe,
  input wire logic [31:0]              pin_out,
  input wire logic                     osc_clk_sel,
  input wire logic                     clkout_active
);
  logic [31:0] wk;
  logic [31:0] sp;
  logic [31:0] pu;
  logic [31:0] pd;
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      wk[i] = pin_drv[i].weak_pu;
      sp[i] = pin_drv[i].strong_pu;
      pu[i] = |pin_drv[i][3:1];
      pd[i] = pin_drv[i].pull_down;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  rd_wait_a: assert property ($rose(avs_read) |-> avs_waitrequest)
    else $error("read answered without wait state");
  rd_answer_a: assert property (avs_read && avs_waitrequest
      |=> !avs_waitrequest)
    else $error("read wait longer than one cycle");
  wr_nowait_a: assert property (avs_write |-> !avs_waitrequest)
    else $error("write stalled");
  rd_upper_a: assert property (avs_read && !avs_waitrequest
      |-> avs_readdata[31:8] == 24'h0)
    else $error("read data upper bytes not zero");
  bus_od_a: assert property (pu[11:10] == 2'b00)
    else $error("bus pin pull-up on");
  drive_excl_a: assert property ((sp & pd) == 32'h0)
    else $error("strong up and down together");
  out_level_a: assert property (pin_out == ~pd)
    else $error("pin out disagrees with pull-down");
  oe_any_a: assert property (pin_oe == (pu | pd))
    else $error("output enable disagrees with drivers");
  weak_sense_a: assert property ((wk & ~$past(pin_in)) == 32'h0)
    else $error("weak pull-up on a low pin");
  clk_div_a: assert property (
      osc_clk_sel && clkout_active && $past(clkout_active) &&
      $past(clkout_active, 2) && pin_oe[24] && $past(pin_oe[24], 2)
      |-> pd[24] != $past(pd[24], 2))
    else $error("clock output not divided by four");
  cover property (avs_read && !avs_waitrequest);
  cover property ($rose(sp[0]));
  cover property (clkout_active);
endmodule

bind gpc_top gpc_top_properties u_gpc_top_properties (.clk(clk), .rst(rst),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .pin_drv(pin_drv),
  .pin_oe(pin_oe), .pin_out(pin_out), .osc_clk_sel(osc_clk_sel),
  .clkout_active(clkout_active));

// ### verification/gpc_pad_model.sv
`timescale 1ns/1ps
// ====
// pads: external pulls, resistors on the bus pins
module gpc_pad_model #(
  parameter logic [31:0] PULLED = 32'h0000_0c00
) (
  input wire logic                     clk,
  input wire gpc_pkg::gpc_drv_s [31:0] pin_drv,
  input wire logic [31:0]              ext_low,
  output logic [31:0]                  pin_in
);
  logic [31:0] last_q = 32'h0;
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (ext_low[i] || pin_drv[i].pull_down)
        pin_in[i] = 1'b0;
      else if (|pin_drv[i][3:1] || PULLED[i])
        pin_in[i] = 1'b1;
      else
        pin_in[i] = ~last_q[i]; // floating pad wanders, never holds
    end
  end
  always_ff @(posedge clk) last_q <= pin_in;
endmodule

// ### verification/tb.sv
`timescale 1ns/1ps
`include "gpc_cfg.svh"
module tb;
  logic                     clk = 1'b0;
  logic                     rst = 1'b1;
  logic [5:0]               avs_address = 6'h00;
  logic                     avs_read = 1'b0;
  logic                     avs_write = 1'b0;
  logic [31:0]              avs_writedata = 32'h0;
  logic [31:0]              avs_readdata;
  logic                     avs_waitrequest;
  gpc_pkg::gpc_rmw_s        rmw_cmd = '0;
  logic                     xtal_sel = 1'b0;
  logic                     osc_clk_sel = 1'b0;
  logic [31:0]              pin_in, pin_oe, pin_out, ext_low = 32'h0;
  gpc_pkg::gpc_drv_s [31:0] pin_drv;
  logic [3:0]               schmitt_sel;
  logic                     t0_en, t1_en, clkout_active, prev;
  int                       n_mismatch = 0;
  int                       check_count = 0;
  int                       k;
  gpc_top u_gpc_top (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rmw_cmd(rmw_cmd), .xtal_sel(xtal_sel), .osc_clk_sel(osc_clk_sel),
    .pin_in(pin_in), .pin_drv(pin_drv), .pin_oe(pin_oe), .pin_out(pin_out),
    .schmitt_sel(schmitt_sel), .t0_toggle_en(t0_en), .t1_toggle_en(t1_en),
    .clkout_active(clkout_active));
  gpc_pad_model u_gpc_pad_model (.clk(clk), .pin_drv(pin_drv),
    .ext_low(ext_low), .pin_in(pin_in));
  initial begin
    forever #2 clk = ~clk;
  end
  // ====
  // tasks
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= 1'b1;
    @(posedge clk iff !avs_waitrequest);
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge clk);
    avs_address <= a;
    avs_read <= 1'b1;
    @(posedge clk iff !avs_waitrequest);
    chk("readdata", avs_readdata, {24'h0, e});
    avs_read <= 1'b0;
  endtask
  // waits out the pin sampling flop before looking
  task automatic dc(input int p, input logic [3:0] e);
    repeat (3) @(posedge clk);
    #1;
    chk("pin_drv", 4'(pin_drv[p]), e);
  endtask
  task automatic rmw(input logic [1:0] op, input logic [2:0] b,
                     input logic [7:0] v);
    @(posedge clk);
    rmw_cmd <= '{1'b1, 2'd2, op, b, v};
    @(posedge clk);
    rmw_cmd.valid <= 1'b0;
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #40000;
    n_mismatch++;
    $display("timeout");
    conclude();
  end
  // ====
  // tests
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (k = 0; k < 12; k++)
      rd(6'(4 * k), (k == 3) ? 8'h03 : ((k < 4) ? 8'hff : 8'h00));
    dc(10, 4'h0);
    dc(0, 4'hc);
    $display("test reset done");
    wr(`GPC_OFF_LATCH0, 8'hfe);
    dc(0, 4'h1);
    wr(`GPC_OFF_LATCH0, 8'hff);
    k = 0;
    repeat (4) begin
      #1;
      k += pin_drv[0].strong_pu;
      @(posedge clk);
    end
    chk("strong_cycles", k, 2);
    wr(`GPC_OFF_LATCH0, 8'hfe);
    wr(`GPC_OFF_LATCH0, 8'hff);
    wr(`GPC_OFF_LATCH0, 8'hfe);
    #1;
    chk("fall_in_pulse", 4'(pin_drv[0]), 4'h1);
    wr(`GPC_OFF_LATCH0, 8'hff);
    ext_low[1] <= 1'b1;
    dc(1, 4'h8);
    rd(`GPC_OFF_PIN0, 8'hfd);
    ext_low[1] <= 1'b0;
    $display("test quasi done");
    for (k = 1; k < 4; k++) begin
      wr(`GPC_OFF_MLO0, (k > 1) ? 8'h10 : 8'h00);
      wr(`GPC_OFF_MHI0, (k != 2) ? 8'h10 : 8'h00);
      dc(4, (k == 1) ? 4'h2 : 4'h0);
      wr(`GPC_OFF_LATCH0, 8'hef);
      dc(4, (k == 2) ? 4'h0 : 4'h1);
      wr(`GPC_OFF_LATCH0, 8'hff);
    end
    $display("test modes done");
    wr(`GPC_OFF_MHI1, 8'h0c);
    dc(10, 4'h0);
    wr(`GPC_OFF_LATCH1, 8'hfb);
    dc(10, 4'h1);
    wr(`GPC_OFF_LATCH1, 8'hff);
    ext_low[11] <= 1'b1;
    rd(`GPC_OFF_PIN1, 8'hf7);
    ext_low[11] <= 1'b0;
    $display("test bus pins done");
    ext_low[16] <= 1'b1;
    rmw(2'd2, 3'd0, 8'h00);
    rd(`GPC_OFF_LATCH2, 8'hff);
    rmw(2'd0, 3'd3, 8'h00);
    rd(`GPC_OFF_LATCH2, 8'hf7);
    rmw(2'd1, 3'd0, 8'h0f);
    rd(`GPC_OFF_LATCH2, 8'h07);
    rmw(2'd3, 3'd0, 8'h05);
    rd(`GPC_OFF_LATCH2, 8'h02);
    ext_low[16] <= 1'b0;
    $display("test rmw done");
    wr(`GPC_OFF_P3CFGA, 8'hac);
    #1;
    chk("cfg", {schmitt_sel, t1_en, t0_en}, 6'h2b);
    rd(`GPC_OFF_P3CFGA, 8'hac);
    wr(`GPC_OFF_P3CFGB, 8'h05);
    osc_clk_sel <= 1'b1;
    k = 0;
    repeat (3) @(posedge clk);
    #1;
    prev = pin_out[24];
    repeat (8) begin
      @(posedge clk);
      #1;
      if (pin_out[24] !== prev)
        k++;
      prev = pin_out[24];
    end
    chk("clkout_edges", k, 4);
    @(posedge clk);
    xtal_sel <= 1'b1;
    osc_clk_sel <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("osc_pins", {pin_oe[25:24], clkout_active}, 3'h0);
    rd(`GPC_OFF_PIN3, 8'h00);
    $display("test clock pins done");
    conclude();
  end
endmodule
